// File: design/fifo_cap_status.sv
/*
 Capability register and Idle/Ready/Reception status flow of a byte-FIFO host
 interface. Answers decoded register and data-port accesses one cycle later.
 Assumes the host bus port decodes offsets, serialises data bursts into one byte
 per request, inserts its own wait states and turns rsp_abort_o into a bus abort.
*/
`timescale 1ns/1ns
module fifo_cap_status
#(
   parameter int unsigned IDLE_TIMEOUT_CYC   = fifo_cap_pkg::TIMEOUT_B_MS *
                                               fifo_cap_pkg::CYC_PER_MS,
   parameter logic [1:0]  XFER_CODE          = fifo_cap_pkg::XFER_64,
   parameter logic [2:0]  REV_CODE           = fifo_cap_pkg::REV_13_PROFILE,
   parameter logic        CAP_BIT31          = 1'b0,
   parameter logic        BURST_FIXED        = 1'b1,
   parameter logic [15:0] BURST_ALLOWANCE    = 16'h0040,
   parameter logic        CMD_READY_IRQ_CAP  = 1'b0,
   parameter logic        FALLING_IRQ_CAP    = 1'b0,
   parameter logic        RISING_IRQ_CAP     = 1'b0,
   parameter logic        HIGH_LEVEL_IRQ_CAP = 1'b0,
   parameter logic        STS_VALID_IRQ_CAP  = 1'b0,
   parameter logic        EXPECT_IN_READY    = 1'b0
)
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic [3:0]  interface_kind_code_i,
   input  wire logic        locality_active_i,
   input  wire logic        locality_changing_i,
   input  wire logic        auto_ready_en_i,
   input  wire logic        acc_req_i,
   input  wire logic        acc_we_i,
   input  wire logic [11:0] acc_addr_i,
   input  wire logic [6:0]  acc_len_i,
   input  wire logic [31:0] acc_wdata_i,
   output logic             rsp_valid_o,
   output logic             rsp_abort_o,
   output logic [31:0]      rsp_rdata_o,
   output logic             cmd_byte_valid_o,
   output logic [7:0]       cmd_byte_o
);
   import fifo_cap_pkg::*;

   typedef struct packed {
      fifo_state_t state;
      logic [31:0] idle_cnt;
      logic        rsp_valid;
      logic        rsp_abort;
      logic [31:0] rsp_rdata;
      logic        byte_valid;
      logic [7:0]  byte_out;
   } top_state_t;

   top_state_t  q;
   top_state_t  d;
   logic        trk_clear;
   logic        trk_byte;
   logic        cmd_complete;
   logic        owner_ok;
   logic        kind_ok;
   logic        is_data;
   logic        size_ok;
   logic [1:0]  n_actions;
   logic [6:0]  max_bytes;
   logic [31:0] cap_word;
   logic [31:0] status_word;
   logic        expect_flag;

   function automatic logic [6:0] max_for_code(input logic [1:0] code);
      case (code)
         XFER_8:  max_for_code = MAX_8_BYTES;
         XFER_32: max_for_code = MAX_32_BYTES;
         XFER_64: max_for_code = MAX_64_BYTES;
         default: max_for_code = MAX_LEGACY_BYTES;
      endcase
   endfunction : max_for_code

   always_comb
   begin
      cap_word                      = '0;
      cap_word[CAP_RSVD_BIT]        = CAP_BIT31;
      cap_word[CAP_REV_LSB +: 3]    = REV_CODE;
      cap_word[CAP_XFER_LSB +: 2]   = XFER_CODE;
      cap_word[CAP_BURST_FIXED_BIT] = BURST_FIXED;
      cap_word[CAP_CMD_READY_BIT]   = CMD_READY_IRQ_CAP;
      cap_word[CAP_FALL_BIT]        = FALLING_IRQ_CAP;
      cap_word[CAP_RISE_BIT]        = RISING_IRQ_CAP;
      cap_word[CAP_LOW_LEVEL_BIT]   = 1'b1;
      cap_word[CAP_HIGH_LEVEL_BIT]  = HIGH_LEVEL_IRQ_CAP;
      cap_word[CAP_OWNER_CHG_BIT]   = 1'b1;
      cap_word[CAP_STS_VALID_BIT]   = STS_VALID_IRQ_CAP;
      cap_word[CAP_RESP_READY_BIT]  = 1'b1;
   end

   assign kind_ok   = (interface_kind_code_i == KIND_FIFO) ||
                      (interface_kind_code_i == KIND_FIFO_ALT);
   assign owner_ok  = locality_active_i && !locality_changing_i;
   assign is_data   = (acc_addr_i == OFF_LEGACY_DATA) || (acc_addr_i == OFF_EXT_DATA);
   assign max_bytes = max_for_code(XFER_CODE);
   assign size_ok   = (acc_len_i != 7'h00) && (acc_len_i <= max_bytes);
   assign n_actions = {1'b0, acc_wdata_i[STS_READY_BIT]} + {1'b0, acc_wdata_i[STS_GO_BIT]} +
                      {1'b0, acc_wdata_i[STS_RETRY_BIT]};

   // Response-available stays low here: the response path lives elsewhere and the
   // host is expected to poll through any gap before it rises.
   assign expect_flag = ((q.state == ST_RECEPTION) && !cmd_complete) ||
                        ((q.state == ST_READY) && EXPECT_IN_READY);

   always_comb
   begin
      status_word                                = '0;
      status_word[STS_VALID_BIT]                 = owner_ok;
      status_word[STS_READY_BIT]                 = (q.state == ST_READY);
      status_word[STS_AVAIL_BIT]                 = 1'b0;
      status_word[STS_EXPECT_BIT]                = expect_flag;
      status_word[STS_BURST_LSB +: 16]           = BURST_ALLOWANCE;
   end

   always_comb
   begin
      d            = q;
      d.rsp_valid  = 1'b0;
      d.rsp_abort  = 1'b0;
      d.rsp_rdata  = '0;
      d.byte_valid = 1'b0;
      trk_byte     = 1'b0;

      if (q.state == ST_IDLE)
      begin
         if (q.idle_cnt < 32'(IDLE_TIMEOUT_CYC))
         begin
            d.idle_cnt = q.idle_cnt + 32'h00000001;
         end
         // Silent step to Ready only inside the timeout window
         if (auto_ready_en_i && (q.idle_cnt < 32'(IDLE_TIMEOUT_CYC)))
         begin
            d.state = ST_READY;
         end
      end
      else
      begin
         d.idle_cnt = IDLE_CNT_RST;
      end

      if (acc_req_i)
      begin
         d.rsp_valid = 1'b1;
         if (acc_addr_i == OFF_CAP)
         begin
            // Writes here are dropped without an abort
            if (!acc_we_i && kind_ok)
            begin
               d.rsp_rdata = cap_word;
            end
         end
         else if (acc_addr_i == OFF_STATUS)
         begin
            if (!acc_we_i)
            begin
               d.rsp_rdata = status_word;
            end
            // Multiple action bits: the whole write is ignored
            else if (owner_ok && (n_actions == 2'h1))
            begin
               if (acc_wdata_i[STS_READY_BIT])
               begin
                  case (q.state)
                     ST_IDLE:      d.state = ST_READY;
                     ST_READY:     d.state = ST_READY;
                     ST_RECEPTION: d.state = ST_IDLE;
                     default:      d.state = ST_IDLE;
                  endcase
               end
               // Execute and retry leave Idle, Ready and Reception as they are
            end
         end
         else if (is_data)
         begin
            if ((acc_addr_i == OFF_EXT_DATA) && (XFER_CODE == XFER_LEGACY))
            begin
               d.rsp_abort = 1'b1;
            end
            else if (!size_ok)
            begin
               d.rsp_abort = 1'b1;
            end
            else if (!acc_we_i)
            begin
               d.rsp_rdata = {24'h000000, FF_BYTE};
            end
            else if (owner_ok)
            begin
               case (q.state)
                  ST_READY:
                  begin
                     d.state      = ST_RECEPTION;
                     d.byte_valid = 1'b1;
                     d.byte_out   = acc_wdata_i[7:0];
                     trk_byte     = 1'b1;
                  end
                  ST_RECEPTION:
                  begin
                     // Bytes past the command length are dropped
                     if (!cmd_complete)
                     begin
                        d.byte_valid = 1'b1;
                        d.byte_out   = acc_wdata_i[7:0];
                        trk_byte     = 1'b1;
                     end
                  end
                  ST_IDLE:      d.state = ST_IDLE;
                  default:      d.state = ST_IDLE;
               endcase
            end
         end
      end

      trk_clear = (d.state != ST_RECEPTION);
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         q       <= '0;
         q.state <= ST_IDLE;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   cmd_length_tracker u_len
   (
      .clock_i      (clock_i),
      .rst_n_i      (rst_n_i),
      .ce_i         (ce_i),
      .clear_i      (trk_clear),
      .byte_valid_i (trk_byte),
      .byte_i       (acc_wdata_i[7:0]),
      .complete_o   (cmd_complete)
   );

   assign rsp_valid_o      = q.rsp_valid;
   assign rsp_abort_o      = q.rsp_abort;
   assign rsp_rdata_o      = q.rsp_rdata;
   assign cmd_byte_valid_o = q.byte_valid;
   assign cmd_byte_o       = q.byte_out;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   logic st_wr;
   logic data_wr;
   logic data_rd;
   assign st_wr   = ce_i && acc_req_i && acc_we_i && (acc_addr_i == OFF_STATUS) && owner_ok;
   assign data_wr = ce_i && acc_req_i && acc_we_i && (acc_addr_i == OFF_LEGACY_DATA) &&
                    size_ok && owner_ok;
   assign data_rd = ce_i && acc_req_i && !acc_we_i && (acc_addr_i == OFF_LEGACY_DATA) &&
                    size_ok;

   property p_cap_fixed;
      ce_i && acc_req_i && !acc_we_i && (acc_addr_i == OFF_CAP) && kind_ok |=>
         rsp_valid_o && (rsp_rdata_o[27:11] == 17'h00000) && rsp_rdata_o[4] &&
         rsp_rdata_o[2] && rsp_rdata_o[0] && (rsp_rdata_o[30:28] == REV_CODE) &&
         (rsp_rdata_o[10:9] == XFER_CODE) && (rsp_rdata_o[8] == BURST_FIXED);
   endproperty
   a_cap_fixed: assert property (p_cap_fixed) else $error("capability read wrong");

   property p_cap_invalid;
      ce_i && acc_req_i && (acc_addr_i == OFF_CAP) && (!kind_ok || acc_we_i) |=>
         rsp_valid_o && !rsp_abort_o && (rsp_rdata_o == 32'h00000000);
   endproperty
   a_cap_invalid: assert property (p_cap_invalid) else $error("cap not zero");

   property p_ext_abort;
      ce_i && acc_req_i && (acc_addr_i == OFF_EXT_DATA) && (XFER_CODE == XFER_LEGACY) |=>
         rsp_valid_o && rsp_abort_o;
   endproperty
   a_ext_abort: assert property (p_ext_abort) else $error("no abort on extended port");

   property p_size_ok;
      ce_i && acc_req_i && is_data && size_ok && (XFER_CODE != XFER_LEGACY) |=>
         rsp_valid_o && !rsp_abort_o;
   endproperty
   a_size_ok: assert property (p_size_ok) else $error("legal size aborted");

   property p_idle_noop;
      (q.state == ST_IDLE) && st_wr && !acc_wdata_i[STS_READY_BIT] && !auto_ready_en_i |=>
         (q.state == ST_IDLE) && !expect_flag;
   endproperty
   a_idle_noop: assert property (p_idle_noop) else $error("idle left on go/retry");

   property p_idle_ready;
      (q.state == ST_IDLE) && st_wr && (n_actions == 2'h1) && acc_wdata_i[STS_READY_BIT] |=>
         (q.state == ST_READY) ##1 (!$past(ce_i) || q.state == ST_READY ||
                                    $past(acc_req_i));
   endproperty
   a_idle_ready: assert property (p_idle_ready) else $error("idle ignored ready");

   property p_idle_data;
      (q.state == ST_IDLE) && data_wr && !auto_ready_en_i |=>
         (q.state == ST_IDLE) && !cmd_byte_valid_o;
   endproperty
   a_idle_data: assert property (p_idle_data) else $error("idle took data");

   property p_read_ff;
      // Idle may still take its silent step to Ready while the read is answered
      data_rd |=> rsp_valid_o && (rsp_rdata_o == 32'h000000ff) &&
         ($stable(q.state) || (($past(q.state) == ST_IDLE) && $past(auto_ready_en_i)));
   endproperty
   a_read_ff: assert property (p_read_ff) else $error("data read not ff");

   property p_ready_hold;
      (q.state == ST_READY) && st_wr |=> (q.state == ST_READY);
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready left on status write");

   property p_first_byte;
      (q.state == ST_READY) && data_wr |=>
         (q.state == ST_RECEPTION) && cmd_byte_valid_o && expect_flag &&
         (cmd_byte_o == $past(acc_wdata_i[7:0]));
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("first byte mishandled");

   property p_timeout;
      ce_i && (q.state == ST_IDLE) && (q.idle_cnt >= 32'(IDLE_TIMEOUT_CYC)) && !st_wr |=>
         (q.state == ST_IDLE);
   endproperty
   a_timeout: assert property (p_timeout) else $error("idle left after timeout");

   property p_reception_expect;
      ce_i && acc_req_i && !acc_we_i && (acc_addr_i == OFF_STATUS) &&
         (q.state == ST_RECEPTION) && !cmd_complete |=> rsp_rdata_o[STS_EXPECT_BIT];
   endproperty
   a_reception_expect: assert property (p_reception_expect) else $error("expect low");

   c_auto_ready:  cover property ((q.state == ST_IDLE) ##1 (q.state == ST_READY));
   c_reception:   cover property ((q.state == ST_READY) ##1 (q.state == ST_RECEPTION));
   c_ext_abort:   cover property (rsp_abort_o);
   c_cmd_done:    cover property ((q.state == ST_RECEPTION) && cmd_complete);

endmodule : fifo_cap_status

// File: design/fifo_cap_pkg.sv
/*
 Constants, field layouts and state codes shared by the byte-FIFO capability and
 status-flow block and its command length tracker.
 Assumes a single 25 MHz clock and accesses already decoded by the host bus port.
*/
package fifo_cap_pkg;

   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned TIMEOUT_B_MS     = 200;
   localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;

   localparam logic [11:0] OFF_STATUS       = 12'h000;
   localparam logic [11:0] OFF_CAP          = 12'h004;
   localparam logic [11:0] OFF_LEGACY_DATA  = 12'h008;
   localparam logic [11:0] OFF_EXT_DATA     = 12'h00c;

   localparam int STS_VALID_BIT             = 7;
   localparam int STS_READY_BIT             = 6;
   localparam int STS_GO_BIT                = 5;
   localparam int STS_AVAIL_BIT             = 4;
   localparam int STS_EXPECT_BIT            = 3;
   localparam int STS_RETRY_BIT             = 1;
   localparam int STS_BURST_LSB             = 8;

   localparam int CAP_RSVD_BIT              = 31;
   localparam int CAP_REV_LSB               = 28;
   localparam int CAP_XFER_LSB              = 9;
   localparam int CAP_BURST_FIXED_BIT       = 8;
   localparam int CAP_CMD_READY_BIT         = 7;
   localparam int CAP_FALL_BIT              = 6;
   localparam int CAP_RISE_BIT              = 5;
   localparam int CAP_LOW_LEVEL_BIT         = 4;
   localparam int CAP_HIGH_LEVEL_BIT        = 3;
   localparam int CAP_OWNER_CHG_BIT         = 2;
   localparam int CAP_STS_VALID_BIT         = 1;
   localparam int CAP_RESP_READY_BIT        = 0;

   localparam logic [3:0] KIND_FIFO         = 4'h0;
   localparam logic [3:0] KIND_FIFO_ALT     = 4'hf;

   localparam logic [1:0] XFER_LEGACY       = 2'h0;
   localparam logic [1:0] XFER_8            = 2'h1;
   localparam logic [1:0] XFER_32           = 2'h2;
   localparam logic [1:0] XFER_64           = 2'h3;
   localparam logic [6:0] MAX_LEGACY_BYTES  = 7'h04;
   localparam logic [6:0] MAX_8_BYTES       = 7'h08;
   localparam logic [6:0] MAX_32_BYTES      = 7'h20;
   localparam logic [6:0] MAX_64_BYTES      = 7'h40;

   localparam logic [2:0] REV_LEGACY        = 3'h0;
   localparam logic [2:0] REV_13            = 3'h2;
   localparam logic [2:0] REV_13_PROFILE    = 3'h3;

   localparam logic [31:0] CMD_MIN_LEN      = 32'h0000000a;
   localparam logic [31:0] LEN_FIRST_IDX    = 32'h00000002;
   localparam logic [31:0] LEN_LAST_IDX     = 32'h00000005;
   localparam logic [7:0]  FF_BYTE          = 8'hff;
   localparam logic [31:0] IDLE_CNT_RST     = 32'h00000000;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b001,
      ST_READY     = 3'b010,
      ST_RECEPTION = 3'b100
   } fifo_state_t;

endpackage : fifo_cap_pkg

// File: design/cmd_length_tracker.sv
/*
 Counts command bytes, captures the big-endian length from the header and flags
 when the whole command has arrived.
 Assumes one byte per strobe on the same clock and a clear while no command runs.
*/
`timescale 1ns/1ns
module cmd_length_tracker
(
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       clear_i,
   input  wire logic       byte_valid_i,
   input  wire logic [7:0] byte_i,
   output logic            complete_o
);
   import fifo_cap_pkg::*;

   typedef struct packed {
      logic [31:0] cnt;
      logic [31:0] len;
      logic        done;
   } trk_state_t;

   trk_state_t q;
   trk_state_t d;

   always_comb
   begin
      d = q;
      if (clear_i)
      begin
         d = '0;
      end
      else if (byte_valid_i && !q.done)
      begin
         if (q.cnt >= LEN_FIRST_IDX && q.cnt <= LEN_LAST_IDX)
         begin
            d.len = {q.len[23:0], byte_i};
         end
         d.cnt  = q.cnt + 32'h00000001;
         // Length is trusted only once the shortest legal header is in
         d.done = (d.cnt >= CMD_MIN_LEN) && (d.cnt >= d.len);
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   assign complete_o = q.done;

endmodule : cmd_length_tracker

// File: bench/host_model.sv
/*
 Host-side partner: issues one decoded access at a time and collects the answer.
 Assumes the device answers exactly one cycle after it takes a request.
*/
`timescale 1ns/1ns
module host_model
(
   input  wire logic        clock_i,
   input  wire logic        rsp_valid_i,
   input  wire logic        rsp_abort_i,
   input  wire logic [31:0] rsp_rdata_i,
   output logic             acc_req_o,
   output logic             acc_we_o,
   output logic [11:0]      acc_addr_o,
   output logic [6:0]       acc_len_o,
   output logic [31:0]      acc_wdata_o
);
   initial
   begin
      acc_req_o   = 1'b0;
      acc_we_o    = 1'b0;
      acc_addr_o  = 12'h000;
      acc_len_o   = 7'h01;
      acc_wdata_o = 32'h00000000;
   end

   // Write data is inverted once released so a stale value never passes for a held one
   task automatic access(input logic we, input logic [11:0] addr, input logic [6:0] len,
                         input logic [31:0] wdata, output logic vld, output logic abt,
                         output logic [31:0] rdata);
      @(posedge clock_i);
      acc_req_o   <= 1'b1;
      acc_we_o    <= we;
      acc_addr_o  <= addr;
      acc_len_o   <= len;
      acc_wdata_o <= wdata;
      @(posedge clock_i);
      acc_req_o   <= 1'b0;
      acc_wdata_o <= ~wdata;
      #1;
      vld   = rsp_valid_i;
      abt   = rsp_abort_i;
      rdata = rsp_rdata_i;
   endtask : access
endmodule : host_model

// File: bench/testbench.sv
/*
 Self-checking bench: a 64-byte, a 32-byte and a legacy-only instance share one host.
 Assumes a 16-cycle idle timeout in place of the long production value.
*/
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
      end \
   end
module testbench;
   import fifo_cap_pkg::*;
   localparam logic [31:0] W_IDLE  = 32'h00004080;
   localparam logic [31:0] W_READY = 32'h000040c0;
   localparam logic [31:0] W_RECV  = 32'h00004088;
   logic        clock_i, rst_n_i, ce_i, loc_act, loc_chg, auto_rdy;
   logic [3:0]  kind;
   logic        acc_req, acc_we, rsp_valid, rsp_abort, cmd_vld, l_valid, l_abort, vld, abt;
   logic        m_valid, m_abort;
   logic [31:0] m_rdata;
   logic [11:0] acc_addr;
   logic [6:0]  acc_len;
   logic [31:0] acc_wdata, rsp_rdata, l_rdata, rd;
   logic [7:0]  cmd_byte;
   logic [7:0]  cmd [10] = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00,
                             8'h01, 8'h44};
   int          err_total, checked, cycles;

   fifo_cap_status #(.IDLE_TIMEOUT_CYC(16)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .ce_i(ce_i), .interface_kind_code_i(kind), .locality_active_i(loc_act),
      .locality_changing_i(loc_chg), .auto_ready_en_i(auto_rdy), .acc_req_i(acc_req),
      .acc_we_i(acc_we), .acc_addr_i(acc_addr), .acc_len_i(acc_len),
      .acc_wdata_i(acc_wdata), .rsp_valid_o(rsp_valid), .rsp_abort_o(rsp_abort),
      .rsp_rdata_o(rsp_rdata), .cmd_byte_valid_o(cmd_vld), .cmd_byte_o(cmd_byte));
   fifo_cap_status #(.IDLE_TIMEOUT_CYC(16), .XFER_CODE(XFER_LEGACY)) dut_legacy (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .interface_kind_code_i(kind),
      .locality_active_i(loc_act), .locality_changing_i(loc_chg), .auto_ready_en_i(auto_rdy),
      .acc_req_i(acc_req), .acc_we_i(acc_we), .acc_addr_i(acc_addr), .acc_len_i(acc_len),
      .acc_wdata_i(acc_wdata), .rsp_valid_o(l_valid), .rsp_abort_o(l_abort),
      .rsp_rdata_o(l_rdata), .cmd_byte_valid_o(), .cmd_byte_o());
   // A 32-byte instance that also raises expect while Ready
   fifo_cap_status #(.IDLE_TIMEOUT_CYC(16), .XFER_CODE(XFER_32),
      .EXPECT_IN_READY(1'b1)) dut_mid (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .interface_kind_code_i(kind),
      .locality_active_i(loc_act), .locality_changing_i(loc_chg), .auto_ready_en_i(auto_rdy),
      .acc_req_i(acc_req), .acc_we_i(acc_we), .acc_addr_i(acc_addr), .acc_len_i(acc_len),
      .acc_wdata_i(acc_wdata), .rsp_valid_o(m_valid), .rsp_abort_o(m_abort),
      .rsp_rdata_o(m_rdata), .cmd_byte_valid_o(), .cmd_byte_o());
   host_model host (.clock_i(clock_i), .rsp_valid_i(rsp_valid), .rsp_abort_i(rsp_abort),
      .rsp_rdata_i(rsp_rdata), .acc_req_o(acc_req), .acc_we_o(acc_we), .acc_addr_o(acc_addr),
      .acc_len_o(acc_len), .acc_wdata_o(acc_wdata));

   task automatic wr(input logic [11:0] addr, input logic [6:0] len, input logic [31:0] wd);
      host.access(1'b1, addr, len, wd, vld, abt, rd);
   endtask : wr

   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
      host.access(1'b0, addr, 7'h01, 32'h00000000, vld, abt, rd);
      `CHK({vld, abt, rd}, {2'b10, exp})
   endtask : rd_chk

   task automatic t_cap();
      rd_chk(OFF_CAP, 32'h30000715);
      `CHK({l_valid, l_abort, l_rdata}, {2'b10, 32'h30000115})
      `CHK({m_valid, m_abort, m_rdata}, {2'b10, 32'h30000515})
      @(posedge clock_i) kind <= KIND_FIFO_ALT;
      rd_chk(OFF_CAP, 32'h30000715);
      @(posedge clock_i) kind <= 4'h1;
      rd_chk(OFF_CAP, 32'h00000000);
      @(posedge clock_i) kind <= KIND_FIFO;
      wr(OFF_CAP, 7'h04, 32'hffffffff);
      `CHK({vld, abt, rd}, {2'b10, 32'h00000000})
      rd_chk(OFF_CAP, 32'h30000715);
   endtask : t_cap

   task automatic t_ports();
      wr(OFF_EXT_DATA, 7'h01, 32'h00000011);
      `CHK({l_valid, l_abort, abt, cmd_vld}, 4'b1100)
      wr(OFF_LEGACY_DATA, 7'h04, 32'h00000022);
      `CHK({l_abort, abt}, 2'b00)
      wr(OFF_LEGACY_DATA, 7'h05, 32'h00000022);
      `CHK(l_abort, 1'b1)
      wr(OFF_EXT_DATA, 7'h40, 32'h00000033);
      `CHK({vld, abt}, 2'b10)
      `CHK(m_abort, 1'b1)
      wr(OFF_EXT_DATA, 7'h20, 32'h00000033);
      `CHK({abt, m_abort}, 2'b00)
      wr(OFF_EXT_DATA, 7'h41, 32'h00000033);
      `CHK(abt, 1'b1)
      wr(OFF_LEGACY_DATA, 7'h00, 32'h00000033);
      `CHK(abt, 1'b1)
   endtask : t_ports

   task automatic t_idle();
      rd_chk(OFF_STATUS, W_IDLE);
      wr(OFF_STATUS, 7'h01, 32'h00000002);
      rd_chk(OFF_STATUS, W_IDLE);
      wr(OFF_STATUS, 7'h01, 32'h00000020);
      rd_chk(OFF_STATUS, W_IDLE);
      wr(OFF_LEGACY_DATA, 7'h01, 32'h000000a5);
      `CHK(cmd_vld, 1'b0)
      rd_chk(OFF_LEGACY_DATA, 32'h000000ff);
      wr(OFF_STATUS, 7'h01, 32'h00000060);
      rd_chk(OFF_STATUS, W_IDLE);
      wr(OFF_STATUS, 7'h01, 32'h00000040);
      rd_chk(OFF_STATUS, W_READY);
      `CHK(m_rdata, 32'h000040c8)
   endtask : t_idle

   task automatic t_ready();
      logic [31:0] act [3] = '{32'h00000002, 32'h00000020, 32'h00000040};
      foreach (act[i])
      begin
         wr(OFF_STATUS, 7'h01, act[i]);
         rd_chk(OFF_STATUS, W_READY);
      end
      rd_chk(OFF_EXT_DATA, 32'h000000ff);
      rd_chk(OFF_STATUS, W_READY);
   endtask : t_ready

   // A fresh 10-byte command is sent here whole; a byte past its end is then dropped
   task automatic t_rx();
      for (int i = 0; i < 10; i++)
      begin
         wr((i == 0) ? OFF_LEGACY_DATA : OFF_EXT_DATA, (i == 0 || i == 9) ? 7'h01 : 7'h04,
            {24'h000000, cmd[i]});
         `CHK({abt, cmd_vld, cmd_byte}, {2'b01, cmd[i]})
         if (i == 0 || i == 8)
            rd_chk(OFF_STATUS, W_RECV);
      end
      rd_chk(OFF_STATUS, W_IDLE);
      wr(OFF_EXT_DATA, 7'h01, 32'h00000077);
      `CHK(cmd_vld, 1'b0)
      wr(OFF_STATUS, 7'h01, 32'h00000040);
      rd_chk(OFF_STATUS, W_IDLE);
   endtask : t_rx

   task automatic t_owner();
      @(posedge clock_i) loc_act <= 1'b0;
      rd_chk(OFF_STATUS, 32'h00004000);
      wr(OFF_STATUS, 7'h01, 32'h00000040);
      @(posedge clock_i) loc_act <= 1'b1;
      loc_chg <= 1'b1;
      rd_chk(OFF_STATUS, 32'h00004000);
      wr(OFF_STATUS, 7'h01, 32'h00000040);
      @(posedge clock_i) loc_chg <= 1'b0;
      rd_chk(OFF_STATUS, W_IDLE);
   endtask : t_owner

   task automatic t_auto();
      repeat (20) @(posedge clock_i);
      auto_rdy <= 1'b1;
      repeat (4) @(posedge clock_i);
      rd_chk(OFF_STATUS, W_IDLE);
      wr(OFF_STATUS, 7'h01, 32'h00000040);
      wr(OFF_LEGACY_DATA, 7'h01, 32'h00000080);
      wr(OFF_STATUS, 7'h01, 32'h00000040);
      rd_chk(OFF_STATUS, W_READY);
      @(posedge clock_i) auto_rdy <= 1'b0;
   endtask : t_auto

   // A byte offered while the enable is low must not be taken
   task automatic t_freeze();
      @(posedge clock_i) ce_i <= 1'b0;
      wr(OFF_LEGACY_DATA, 7'h01, 32'h00000055);
      `CHK({vld, cmd_vld}, 2'b00)
      @(posedge clock_i) ce_i <= 1'b1;
      rd_chk(OFF_STATUS, W_READY);
   endtask : t_freeze

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   initial
   begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_total++;
         $display("[FAIL] %0t run did not finish", $time);
         finish_test();
      end
   end

   initial
   begin
      err_total = 0;
      checked   = 0;
      cycles    = 0;
      rst_n_i   = 1'b0;
      ce_i      = 1'b1;
      kind      = KIND_FIFO;
      loc_act   = 1'b1;
      loc_chg   = 1'b0;
      auto_rdy  = 1'b0;
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_cap();
      t_ports();
      t_idle();
      t_ready();
      t_rx();
      t_owner();
      t_auto();
      t_freeze();
      finish_test();
   end
endmodule : testbench
